/* core/cps_pkg.sv */
package cps_pkg;
  // ==========================================================
  // register map (byte addresses on the word bus)
  localparam logic [3:0] REG_CTRL = 4'h0;   // control word
  localparam logic [3:0] REG_STATUS = 4'h4; // state word
  // control fields
  localparam int CTRL_EDGE_BIT = 0;         // capture edge select
  localparam int CTRL_MODE_LSB = 1;         // two-bit width mode
  localparam int CTRL_REF_BIT = 3;          // pll reference select
  localparam logic [3:0] CTRL_RESET = 4'h1; // rising edge, 12-bit lf, pixel ref
  // status fields
  localparam int STAT_LOCK_BIT = 0;         // serializer locked
  localparam int STAT_VIOL_BIT = 1;         // sync spacing violation, w1c
  // ==========================================================
  // width and frequency modes
  localparam logic [1:0] MODE_LF12 = 2'h0;  // 12-bit, divide by 1
  localparam logic [1:0] MODE_HF12 = 2'h1;  // 12-bit, divide by 1.5
  localparam logic [1:0] MODE_TEN = 2'h2;   // 10-bit, divide by 2
  // payload bits per serial frame in each mode
  localparam logic [5:0] PAY_LF12 = 6'h0E;  // one pixel of 14
  localparam logic [5:0] PAY_HF12 = 6'h15;  // three pixels in two frames
  localparam logic [5:0] PAY_TEN = 6'h18;   // two pixels of 12
  localparam logic [5:0] PIX_W12 = 6'h0E;   // 12 data + 2 sync
  localparam logic [5:0] PIX_W10 = 6'h0C;   // 10 data + 2 sync
  localparam int FRAME_BITS = 28;           // bits per serial frame
  localparam int SLOT_BITS = 25;            // payload plus control bit
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 125;             // system clock rate
  localparam int LOCK_TIME_US = 1000;       // lock wait, within the 2 ms bound
  localparam int LOCK_CYC_DEF = LOCK_TIME_US * CLK_MHZ;
  localparam logic [5:0] LAT_TEN = 6'h26;   // 38 pixel periods
  localparam logic [5:0] LAT_12 = 6'h0D;    // 13 pixel periods
  localparam int DLY_DEPTH = 38;            // longest latency line
  localparam logic [3:0] ACT_RELOAD = 4'hF; // pixel clock activity window
  localparam logic [3:0] SYNC_GAP = 4'h9;   // ten-bit least toggle spacing - 1
  // lock sequencer states
  typedef enum logic [2:0] {
    ST_PD = 3'b001,
    ST_ACQ = 3'b010,
    ST_LOCK = 3'b100
  } cps_lock_t;
endpackage

/* core/cps_enc_if.sv */
// ============================================================
// slot hand-off from framer to line encoder
interface cps_enc_if;
  logic slot_vld;                     // slot leaves delay line
  logic [24:0] slot;                  // control bit and payload
  logic idle_high;                    // power-down, drive static high
  logic [27:0] word;                  // encoded serial frame
  logic word_stb;                     // one frame on the line
  modport framer (output slot_vld, slot, idle_high, input word, word_stb);
  modport enc (input slot_vld, slot, idle_high, output word, word_stb);
endinterface

/* core/cps_enc.sv */
module cps_enc
  import cps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // slot stream
  cps_enc_if.enc e
);
  // ==========================================================
  // parity and dc balance
  logic [25:0] body;                  // slot with even parity bit
  logic inv;                          // invert to keep ones at or below half
  always_comb begin
    body = {^e.slot, e.slot};
    inv = ($countones(body) > 13);
  end

  // ==========================================================
  // output frame: marker pair gives an embedded clock edge per frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e.word <= '1;
      e.word_stb <= 1'b0;
    end else if (e.idle_high) begin
      e.word <= '1;                   // static high while powered down
      e.word_stb <= 1'b0;
    end else if (e.slot_vld) begin
      e.word <= {~inv, inv, inv ? ~body : body};
      e.word_stb <= 1'b1;
    end else begin
      e.word_stb <= 1'b0;
    end
  end

  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_parity_even: assert property (e.word_stb |-> ^e.word[25:0] == 1'b0)
    else $error("frame parity not even");
  chk_dc_balance: assert property (e.word_stb |-> $countones(e.word[25:0]) <= 13)
    else $error("frame not dc balanced");
  chk_clock_marker: assert property (e.word_stb |-> e.word[27] != e.word[26])
    else $error("frame marker edge missing");
endmodule // cps_enc

/* core/cps_front.sv */
// Local design decisions: the address map and the Avalon-MM interface to the registers.
module cps_front
  import cps_pkg::*;
#(
  parameter int unsigned LOCK_CYC = LOCK_CYC_DEF // lock wait in clocks
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // imager pins
  input wire logic PCLK,
  input wire logic [11:0] DATA_IN,
  input wire logic LINE_SYNC,
  input wire logic FRAME_SYNC,
  input wire logic CTRL_BIT,
  input wire logic POWERDOWN_N_PIN,
  // serial side
  output logic [27:0] DOUT_WORD,
  output logic DOUT_STB,
  output logic LOCKED
);
  // ==========================================================
  // pin synchronisers; stage one feeds stage two only
  logic [16:0] s1_ff;                 // first stage
  logic [16:0] s2_ff;                 // second stage, safe to use
  logic pclk_d_ff;                    // previous pixel clock level
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_ff <= '0;
      s2_ff <= '0;
      pclk_d_ff <= 1'b0;
    end else begin
      s1_ff <= {POWERDOWN_N_PIN, CTRL_BIT, PCLK, FRAME_SYNC, LINE_SYNC, DATA_IN};
      s2_ff <= s1_ff;
      pclk_d_ff <= s2_ff[14];
    end
  end
  logic [11:0] dat_s;                 // data bits
  logic [1:0] sync_s;                 // {frame, line} sync
  logic pclk_s;                       // pixel clock level
  logic ctrl_s;                       // control channel bit
  logic pd_n_s;                       // power-down pin, low active
  assign dat_s = s2_ff[11:0];
  assign sync_s = s2_ff[13:12];
  assign pclk_s = s2_ff[14];
  assign ctrl_s = s2_ff[15];
  assign pd_n_s = s2_ff[16];

  // ==========================================================
  // control register
  logic [3:0] ctrl_ff;                // edge, mode, reference
  logic viol_ff;                      // sticky sync spacing error
  logic edge_sel;                     // 1 rising, 0 falling
  logic [1:0] mode;                   // width and frequency mode
  logic ref_osc;                      // 1 external oscillator reference
  logic ten;                          // ten-bit mode
  assign edge_sel = ctrl_ff[CTRL_EDGE_BIT];
  assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];
  assign ref_osc = ctrl_ff[CTRL_REF_BIT];
  assign ten = (mode == MODE_TEN);

  // ==========================================================
  // bus slave: one wait cycle, answer on the second edge
  logic bus_req;                      // request present
  logic bus_go;                       // edge where master sees waitrequest low
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_go = bus_req & ~AVS_WAITREQUEST;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
    end
  end
  // read data loaded during the wait cycle, stable at the answer edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ & AVS_WAITREQUEST) begin
      unique case (AVS_ADDRESS)
        REG_CTRL: AVS_READDATA <= {28'h0, ctrl_ff};
        REG_STATUS: AVS_READDATA <= {30'h0, viol_ff, LOCKED};
        default: AVS_READDATA <= '0; // unmapped reads zero
      endcase
    end
  end
  // settings may be rewritten any time; a change forces a fresh lock
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= CTRL_RESET;
    end else if (bus_go & AVS_WRITE & AVS_BYTEENABLE[0] & (AVS_ADDRESS == REG_CTRL)) begin
      ctrl_ff <= AVS_WRITEDATA[3:0];
    end
  end

  // ==========================================================
  // capture on the selected pixel clock edge
  logic cap;                          // one pixel taken this cycle
  logic [13:0] pix;                   // pixel with sync in low bits
  logic [5:0] pix_w;                  // pixel width in bits
  logic [5:0] pay_w;                  // payload bits per frame
  always_comb begin
    cap = edge_sel ? (pclk_s & ~pclk_d_ff) : (~pclk_s & pclk_d_ff);
    pix = ten ? {2'h0, dat_s[9:0], sync_s} : {dat_s, sync_s};
    pix_w = ten ? PIX_W10 : PIX_W12;
    unique case (mode)
      MODE_HF12: pay_w = PAY_HF12;
      MODE_TEN: pay_w = PAY_TEN;
      default: pay_w = PAY_LF12;      // code 3 runs as low frequency
    endcase
  end

  // ==========================================================
  // lock sequencer; a pixel clock reference needs recent edges
  cps_lock_t st_ff;                   // lock state
  logic [31:0] lock_cnt_ff;           // acquisition timer
  logic [3:0] act_ff;                 // pixel clock activity timer
  logic [3:0] cfg_ff;                 // settings seen at lock
  logic ref_ok;                       // reference clock running
  logic locked;                       // link carries frames
  assign ref_ok = ref_osc | (act_ff != 4'h0);
  assign locked = (st_ff == ST_LOCK);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      act_ff <= 4'h0;
    end else if (pclk_s != pclk_d_ff) begin
      act_ff <= ACT_RELOAD;
    end else if (act_ff != 4'h0) begin
      act_ff <= act_ff - 4'h1;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= ST_PD;
      lock_cnt_ff <= '0;
      cfg_ff <= CTRL_RESET;
    end else begin
      unique case (st_ff)
        ST_PD: begin
          lock_cnt_ff <= '0;
          if (pd_n_s) begin
            st_ff <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (!pd_n_s) begin
            st_ff <= ST_PD;
          end else if (!ref_ok) begin
            lock_cnt_ff <= '0;        // wait for a live reference
          end else if (lock_cnt_ff == 32'(LOCK_CYC - 1)) begin
            st_ff <= ST_LOCK;
            cfg_ff <= ctrl_ff;
          end else begin
            lock_cnt_ff <= lock_cnt_ff + 32'h1;
          end
        end
        ST_LOCK: begin
          lock_cnt_ff <= '0;
          if (!pd_n_s) begin
            st_ff <= ST_PD;
          end else if (!ref_ok || (cfg_ff != ctrl_ff)) begin
            st_ff <= ST_ACQ;
          end
        end
      endcase
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LOCKED <= 1'b0;
    end else begin
      LOCKED <= locked;
    end
  end

  // ==========================================================
  // bit accumulator: packs pixels into frame payloads
  logic [31:0] acc_ff;                // pending bits, oldest at bit 0
  logic [5:0] cnt_ff;                 // pending bit count
  logic [31:0] acc_sum;               // with the new pixel appended
  logic [5:0] cnt_sum;                // count with the new pixel
  logic frame_rdy;                    // a full payload is pending
  logic [31:0] pay_mask;              // keeps payload bits only
  always_comb begin
    acc_sum = acc_ff | (32'(pix) << cnt_ff);
    cnt_sum = cnt_ff + pix_w;
    frame_rdy = cap & locked & (cnt_sum >= pay_w);
    pay_mask = (32'h1 << pay_w) - 32'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_ff <= '0;
      cnt_ff <= '0;
    end else if (!locked) begin
      acc_ff <= '0;
      cnt_ff <= '0;
    end else if (frame_rdy) begin
      acc_ff <= acc_sum >> pay_w;
      cnt_ff <= cnt_sum - pay_w;
    end else if (cap) begin
      acc_ff <= acc_sum;
      cnt_ff <= cnt_sum;
    end
  end

  // ==========================================================
  // latency line, advanced once per pixel period
  logic [25:0] dly_ff [DLY_DEPTH];    // valid flag and slot
  logic [5:0] lat;                    // tap depth for this mode
  assign lat = ten ? LAT_TEN : LAT_12;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        dly_ff[i] <= '0;
      end
    end else if (!locked) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        dly_ff[i] <= '0;
      end
    end else if (cap) begin
      dly_ff[0] <= {frame_rdy, ctrl_s, 24'(acc_sum & pay_mask)};
      for (int i = 1; i < DLY_DEPTH; i++) begin
        dly_ff[i] <= dly_ff[i - 1];
      end
    end
  end

  // ==========================================================
  // line encoder; one 28-bit word per frame sets the line rate
  cps_enc_if eif ();
  assign eif.slot_vld = cap & locked & dly_ff[lat - 6'h1][25];
  assign eif.slot = dly_ff[lat - 6'h1][24:0];
  assign eif.idle_high = ~pd_n_s | (st_ff == ST_PD);
  cps_enc u_enc (
    .clk(CLK),
    .rst(RST),
    .e(eif.enc)
  );
  assign DOUT_WORD = eif.word;
  assign DOUT_STB = eif.word_stb;

  // ==========================================================
  // ten-bit sync spacing monitor; imager fault is only reported
  logic [1:0] sync_last_ff;           // sync value at last capture
  logic [3:0] gap_ff;                 // captures since last toggle
  logic sync_tog;                     // sync changed at this capture
  assign sync_tog = cap & (sync_s != sync_last_ff);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_last_ff <= '0;
      gap_ff <= 4'hF;
    end else if (cap) begin
      sync_last_ff <= sync_s;
      gap_ff <= sync_tog ? 4'h0 : ((gap_ff == 4'hF) ? gap_ff : gap_ff + 4'h1);
    end
  end
  // set wins over a same-cycle write-one clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      viol_ff <= 1'b0;
    end else if (ten & sync_tog & (gap_ff < SYNC_GAP)) begin
      viol_ff <= 1'b1;
    end else if (bus_go & AVS_WRITE & AVS_BYTEENABLE[0] & (AVS_ADDRESS == REG_STATUS)
                 & AVS_WRITEDATA[STAT_VIOL_BIT]) begin
      viol_ff <= 1'b0;
    end
  end

  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_pd_static_high: assert property (st_ff == ST_PD |=> DOUT_WORD == '1 && !DOUT_STB)
    else $error("output not static high in power-down");
  chk_no_frame_unlocked: assert property (!locked |=> !DOUT_STB)
    else $error("frame sent before lock");
  chk_lock_wait: assert property ($rose(locked) |-> $past(lock_cnt_ff) == 32'(LOCK_CYC - 1))
    else $error("lock reached at wrong time");
  chk_relock_change: assert property (locked && $changed(ctrl_ff) |=> !locked)
    else $error("settings changed without relock");
  chk_capture_edge: assert property (cap |-> pclk_s == edge_sel)
    else $error("capture on wrong pixel edge");
  chk_acc_bound: assert property (cnt_ff < pay_w || !locked || $changed(ctrl_ff))
    else $error("payload bits left over");
  chk_viol_only_ten: assert property ($rose(viol_ff) |-> $past(ten))
    else $error("spacing error outside ten-bit mode");
  // empty packer in low mode: the syncs must land in the low slot bits of that frame
  chk_sync_in_pixel: assert property (
    cap && locked && mode == MODE_LF12 && cnt_ff == 6'h0 |=> dly_ff[0][1:0] == $past(sync_s))
    else $error("sync not taken with data");
  chk_bus_answer: assert property (bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  cov_lock: cover property ($rose(locked));
  cov_ten_frame: cover property (ten && DOUT_STB);
  cov_hf_frame: cover property (mode == MODE_HF12 && DOUT_STB);
  cov_viol: cover property ($rose(viol_ff));
endmodule // cps_front

/* testbench/cps_imager.sv */
// ============================================================
// imager model: drives the parallel pixel bus from the system clock
module cps_imager (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // run control
  input wire logic en,
  input wire logic edge_rise,
  input wire logic [7:0] gap,
  // pixel bus
  output logic pclk,
  output logic [11:0] data,
  output logic line_sync,
  output logic frame_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_ff; // half period of eight clocks
  logic [15:0] idx_ff; // pixels launched in this run
  // ============================================================
  // pixel clock runs only while enabled and stops low between runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pclk <= 1'b0;
      div_ff <= 3'h0;
      idx_ff <= 16'h0;
      data <= 12'h000;
      line_sync <= 1'b0;
      frame_sync <= 1'b0;
    end else if (en || pclk) begin
      div_ff <= div_ff + 3'h1;
      if (div_ff == 3'h7) begin
        pclk <= ~pclk;
        // launch on the edge opposite the capture edge
        if (pclk == edge_rise) begin
          idx_ff <= idx_ff + 16'h1;
          data <= idx_ff[11:0] * 12'h09D + 12'h035;
          // syncs toggle no closer than gap pixels
          if (int'(idx_ff) % int'(gap) == int'(gap) - 1) begin
            line_sync <= ~line_sync;
            frame_sync <= frame_sync ^ idx_ff[4];
          end
        end
      end
    end else begin
      // released bus: hold time over, data no longer valid
      div_ff <= 3'h0;
      idx_ff <= 16'h0;
      data <= ~data;
    end
  end
endmodule // cps_imager

/* testbench/testbench.sv */
module testbench
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LCYC = 20; // short lock wait for simulation
  // ============================================================
  // design and model wiring
  logic clk, rst, avs_read, avs_write, avs_waitrequest, pclk, line_sync, frame_sync;
  logic ctrl_bit, pd_n, dout_stb, locked, im_en, im_rise, rec, prev;
  logic [3:0] avs_address, avs_be;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [11:0] data_in;
  logic [27:0] dout_word;
  logic [7:0] im_gap;
  logic [1:0] mode;
  logic [13:0] pix[$]; // captured pixels {data, frame, line}
  int n_fail, n_checks, cyc, ncap, nf;
  cps_front #(.LOCK_CYC(LCYC)) dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_be), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PCLK(pclk), .DATA_IN(data_in), .LINE_SYNC(line_sync), .FRAME_SYNC(frame_sync),
    .CTRL_BIT(ctrl_bit), .POWERDOWN_N_PIN(pd_n), .DOUT_WORD(dout_word),
    .DOUT_STB(dout_stb), .LOCKED(locked));
  cps_imager im (.clk(clk), .rst(rst), .en(im_en), .edge_rise(im_rise), .gap(im_gap),
    .pclk(pclk), .data(data_in), .line_sync(line_sync), .frame_sync(frame_sync));
  always #4 clk = ~clk;
  // ============================================================
  // checking and closing
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, runs take under 10000 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // ============================================================
  // avalon master: hold the request until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // bounded wait for the lock flag to reach a level
  task wait_lock(input logic lvl, input int n);
    int i;
    i = 0;
    while (locked !== lvl && i < n) begin
      @(posedge clk);
      i++;
    end
    chk(locked, lvl);
  endtask
  // ============================================================
  // expected frames, worked out from the frame packing rules
  function automatic int lat();
    return (mode == MODE_TEN) ? 38 : 13;
  endfunction
  // capture index that completes frame n
  function automatic int bof(int n);
    if (mode == MODE_TEN) return 2 * n + 1;
    if (mode == MODE_HF12) return 3 * (n / 2) + 1 + (n % 2);
    return n;
  endfunction
  function automatic logic [24:0] slot_of(int n);
    int m;
    m = n / 2;
    if (mode == MODE_TEN) return {ctrl_bit, pix[2 * n + 1][11:0], pix[2 * n][11:0]};
    if (mode == MODE_HF12 && n % 2 == 1)
      return {ctrl_bit, 3'h0, pix[3 * m + 2], pix[3 * m + 1][13:7]};
    if (mode == MODE_HF12) return {ctrl_bit, 3'h0, pix[3 * m + 1][6:0], pix[3 * m]};
    return {ctrl_bit, 10'h000, pix[n]};
  endfunction
  // even parity, then inversion when ones outnumber zeros
  function automatic logic [27:0] enc(logic [24:0] s);
    logic [25:0] b;
    b = {^s, s};
    if ($countones(b) > 13) return {2'b01, ~b};
    return {2'b10, b};
  endfunction
  // frame monitor and pin-side capture record
  always @(posedge clk) begin
    if (rec && dout_stb === 1'b1) begin
      chk(ncap, bof(nf) + lat() + 1);
      chk(dout_word, enc(slot_of(nf)));
      nf++;
    end
    if (rec && pclk !== prev && pclk === im_rise) begin
      pix.push_back({data_in, frame_sync, line_sync});
      ncap++;
    end
    prev = pclk;
  end
  // one mode run on oscillator reference
  task run(input logic [1:0] md, input logic rise, input logic cb, input logic [7:0] gap,
    input int npix);
    int i, n;
    rec = 1'b0;
    im_en <= 1'b0;
    repeat (40) @(posedge clk);
    bus(1'b1, REG_CTRL, {28'h0, 1'b1, md, rise}, r);
    mode = md;
    ctrl_bit <= cb;
    im_rise <= rise;
    im_gap <= gap;
    repeat (5) @(posedge clk);
    chk(locked, 1'b0);
    wait_lock(1'b1, 3 * LCYC);
    bus(1'b1, REG_STATUS, 32'h2, r);
    pix.delete();
    ncap = 0;
    nf = 0;
    rec = 1'b1;
    im_en <= 1'b1;
    repeat (npix * 16) @(posedge clk);
    im_en <= 1'b0;
    repeat (60) @(posedge clk);
    n = 0;
    for (i = 0; bof(i) + lat() < ncap; i++) n++;
    chk(nf, n);
    chk(locked, 1'b1);
  endtask
  // ============================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_be} = {2'b00, 4'h0, 32'h0, 4'hF};
    {ctrl_bit, pd_n, im_en, im_rise, im_gap, mode, rec, prev} = {4'b0001, 8'h5, 2'h0, 2'b00};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(dout_word, 28'hFFFFFFF);
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(4'h8, 32'h0);
    avs_be <= 4'hE;
    bus(1'b1, REG_CTRL, 32'h6, r);
    avs_be <= 4'hF;
    bus(1'b1, 4'h8, 32'h6, r);
    rd_chk(REG_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    chk(locked, 1'b0);
    pd_n <= 1'b1;
    repeat (60) @(posedge clk);
    chk(locked, 1'b0);
    im_en <= 1'b1;
    wait_lock(1'b1, 200);
    im_en <= 1'b0;
    wait_lock(1'b0, 100);
    run(MODE_LF12, 1'b1, 1'b0, 8'h05, 40);
    run(MODE_HF12, 1'b0, 1'b1, 8'h01, 40);
    rd_chk(REG_STATUS, 32'h1);
    run(MODE_TEN, 1'b1, 1'b1, 8'h0A, 80);
    rd_chk(REG_STATUS, 32'h1);
    run(MODE_TEN, 1'b0, 1'b0, 8'h03, 40);
    rd_chk(REG_STATUS, 32'h3);
    bus(1'b1, REG_STATUS, 32'h2, r);
    rd_chk(REG_STATUS, 32'h1);
    pd_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(dout_word, 28'hFFFFFFF);
    chk(locked, 1'b0);
    end_sim();
  end
endmodule // testbench
